// ===== src/dio_exec.v
// execution unit for enable-interrupts, idle, port input, soft interrupt, load accumulator
// assumes the sequencer presents one op per start pulse and waits for done;
// io_ready comes from a pin and is synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "dio_map.vh"

// Contract
// - enable-interrupts clears the mask bit to 0 once the op completes.
// - idle halts execution until reset or an interrupt request arrives.
// - port input reads a 16-bit word and writes it to data memory.
// - port input drives io select low; strobe, read and ready as memory read.
// - soft interrupt takes K 0..31 and jumps to vector K, whatever its source.
// - vectors sit every two words from 0h to 3Eh; target is twice K.
// - load fetches the data word, shifts left by count, writes accumulator.
// - vacated low bits zero; high bits sign-extended only when mode bit is 1.
module dio_exec #(
   parameter DW = 16,                     // data word width
   parameter AW = 16                      // address width
) (
   input  wire          mclk,             // core clock
   input  wire          rst_n,            // synchronous reset, active low
   input  wire          op_start,         // one-cycle request to execute op_code
   input  wire [2:0]    op_code,          // operation select
   input  wire [AW-1:0] dm_addr,          // resolved data-memory address
   input  wire [AW-1:0] port_address,     // I/O port address
   input  wire [4:0]    soft_k,           // soft interrupt number
   input  wire [3:0]    shift_count,      // load shift count
   input  wire          sxm_set,          // pulse: set sign extension mode bit
   input  wire          sxm_clr,          // pulse: clear sign extension mode bit
   input  wire          interrupt_mask_bit_set,         // pulse: disable interrupts
   input  wire          irq_pending,      // interrupt request from interrupt logic
   input  wire [DW-1:0] dm_rdata,         // data-memory read word, valid in the cycle dm_rd is high
   input  wire [DW-1:0] io_rdata,         // external data bus input
   input  wire          io_ready,         // external ready pin
   output wire          op_done,          // one-cycle completion pulse
   output reg           idle_active,      // core is halted in idle
   output reg           interrupt_mask_bit,       // 1 masks maskable interrupts
   output reg           sign_extension_mode_bit,  // 1 sign-extends loads
   output reg           pc_load,          // pulse: load program counter
   output reg  [AW-1:0] pc_target,        // program counter target
   output reg  [31:0]   acc,              // accumulator
   output reg           dm_rd,            // data-memory read request
   output reg           dm_we,            // data-memory write pulse
   output reg  [AW-1:0] dm_waddr,         // data-memory address
   output reg  [DW-1:0] dm_wdata,         // data-memory write word
   output reg           io_space_select_n,        // low during I/O access
   output reg           external_access_strobe,   // low-active external strobe level
   output reg           io_rd_n,          // read strobe, active low
   output reg  [AW-1:0] io_addr           // external address bus
);

   // ==========================================================
   // state machine
   // ST_IDLE_WAIT is the warm-up edge after reset, not the idle op
   localparam ST_IDLE_WAIT = 3'h0;
   localparam ST_READY     = 3'h1;
   localparam ST_IO        = 3'h2;
   localparam ST_LOAD      = 3'h3;
   localparam ST_HALT      = 3'h4;

   reg [2:0]    state_reg;
   reg [2:0]    state_next;
   reg          rdy_meta_reg;
   reg          rdy_sync_reg;
   reg          done_reg;
   reg [3:0]    shift_reg;
   reg [1:0]    io_age_reg;
   wire         io_data_ok;

   // shift with zero fill; high bits follow sign only under mode bit
   function [31:0] shift_load;
      input [15:0] w;
      input [3:0]  n;
      input        sx;
      reg   [31:0] ext;
      begin
         ext = sx ? {{16{w[15]}}, w} : {16'h0000, w};
         shift_load = ext << n;
      end
   endfunction

   assign op_done = done_reg;

   // ==========================================================
   // ready synchroniser: first stage read only by the second
   always @(posedge mclk) begin
      if (!rst_n) begin
         rdy_meta_reg <= 1'b0;
         rdy_sync_reg <= 1'b0;
      end else begin
         rdy_meta_reg <= io_ready;
         rdy_sync_reg <= rdy_meta_reg;
      end
   end

   // ==========================================================
   // next state: only ST_READY accepts an op; busy states drop op_start
   always @* begin
      state_next = state_reg;
      case (state_reg)
         ST_READY: begin
            if (op_start) begin
               case (op_code)
                  `DIO_OP_IDLE: state_next = ST_HALT;
                  `DIO_OP_IN:   state_next = ST_IO;
                  `DIO_OP_LOAD: state_next = ST_LOAD;
                  default:      state_next = ST_READY;
               endcase
            end
         end
         ST_IO:   state_next = io_data_ok ? ST_READY : ST_IO;
         ST_LOAD: state_next = ST_READY;
         ST_HALT: state_next = irq_pending ? ST_READY : ST_HALT;
         default: state_next = ST_READY;
      endcase
   end

   // ==========================================================
   // port read age
   // the synchroniser still shows ready from before the strobe fell for two
   // edges; trusting it earlier would take the bus word before the peer drives it
   // saturates, so a slow peer may hold ready low for as long as it needs
   always @(posedge mclk) begin
      if (!rst_n)
         io_age_reg <= 2'h0;
      else if (state_reg != ST_IO)
         io_age_reg <= 2'h0;
      else if (io_age_reg != `DIO_IO_SYNC_AGE)
         io_age_reg <= io_age_reg + 2'h1;
   end

   assign io_data_ok = (state_reg == ST_IO) && rdy_sync_reg
                       && (io_age_reg == `DIO_IO_SYNC_AGE);

   // ==========================================================
   // datapath
   always @(posedge mclk) begin
      if (!rst_n) begin
         // strobes rest high; mask and mode bits come up set
         state_reg               <= ST_IDLE_WAIT;
         interrupt_mask_bit      <= `DIO_INTERRUPT_MASK_BIT_RST;
         sign_extension_mode_bit <= `DIO_SXM_RST;
         idle_active             <= 1'b0;
         done_reg                <= 1'b0;
         pc_load                 <= 1'b0;
         pc_target               <= {AW{1'b0}};
         acc                     <= 32'h00000000;
         dm_rd                   <= 1'b0;
         dm_we                   <= 1'b0;
         dm_waddr                <= {AW{1'b0}};
         dm_wdata                <= {DW{1'b0}};
         io_space_select_n       <= 1'b1;
         external_access_strobe  <= 1'b1;
         io_rd_n                 <= 1'b1;
         io_addr                 <= {AW{1'b0}};
         shift_reg               <= 4'h0;
      end else begin
         state_reg <= (state_reg == ST_IDLE_WAIT) ? ST_READY : state_next;
         done_reg  <= 1'b0;
         pc_load   <= 1'b0;
         dm_rd     <= 1'b0;
         dm_we     <= 1'b0;
         // set pulses from other logic take effect unless an op overrides below
         if (sxm_set)
            sign_extension_mode_bit <= 1'b1;
         else if (sxm_clr)
            sign_extension_mode_bit <= 1'b0;
         // a same-cycle enable-interrupts op below overrides interrupt_mask_bit_set
         if (interrupt_mask_bit_set)
            interrupt_mask_bit <= 1'b1;
         if (state_reg == ST_READY && op_start) begin
            case (op_code)
               `DIO_OP_ENABLE_INTERRUPTS_OP: begin
                  interrupt_mask_bit <= 1'b0;
                  done_reg           <= 1'b1;
               end
               `DIO_OP_IDLE: idle_active <= 1'b1;
               `DIO_OP_IN: begin
                  io_space_select_n      <= 1'b0;
                  external_access_strobe <= 1'b0;
                  io_rd_n                <= 1'b0;
                  io_addr                <= port_address;
                  dm_waddr               <= dm_addr;
               end
               `DIO_OP_SWI: begin
                  // K is five bits so 0..31 only; vector = 2K, last is 3Eh
                  pc_target <= {{(AW-6){1'b0}}, soft_k, 1'b0};
                  pc_load   <= 1'b1;
                  done_reg  <= 1'b1;
               end
               `DIO_OP_LOAD: begin
                  dm_rd     <= 1'b1;
                  dm_waddr  <= dm_addr;
                  shift_reg <= shift_count;
               end
               default: done_reg <= 1'b1;
            endcase
         end
         // data sampled while strobe low and ready seen, as a memory read
         if (io_data_ok) begin
            dm_wdata               <= io_rdata;
            dm_we                  <= 1'b1;
            io_space_select_n      <= 1'b1;
            external_access_strobe <= 1'b1;
            io_rd_n                <= 1'b1;
            done_reg               <= 1'b1;
         end
         // dm_rdata is taken in the cycle dm_rd stands
         if (state_reg == ST_LOAD) begin
            acc      <= shift_load(dm_rdata, shift_reg, sign_extension_mode_bit);
            done_reg <= 1'b1;
         end
         // an interrupt or reset is the only way out of idle
         if (state_reg == ST_HALT && irq_pending) begin
            idle_active <= 1'b0;
            done_reg    <= 1'b1;
         end
      end
   end

endmodule // dio_exec

`default_nettype wire

// ===== src/dio_map.vh
// constants for the interrupt/idle/port-input/load execution block
// assumes one core clock at 125 MHz and a 16-bit data path
`ifndef DIO_MAP_VH
`define DIO_MAP_VH
// opcode select codes presented by the sequencer
`define DIO_OP_NONE   3'h0
`define DIO_OP_ENABLE_INTERRUPTS_OP   3'h1
`define DIO_OP_IDLE   3'h2
`define DIO_OP_IN     3'h3
`define DIO_OP_SWI    3'h4
`define DIO_OP_LOAD   3'h5
// software interrupt operand range and vector spacing
`define DIO_K_MAX     5'h1F
`define DIO_VEC_LAST  16'h003E
// synchroniser depth: ready is trusted this many edges into a port read
`define DIO_IO_SYNC_AGE 2'h2
// reset values
`define DIO_INTERRUPT_MASK_BIT_RST  1'h1
`define DIO_SXM_RST   1'h1
`endif

// ===== test/dio_exec_chk.sv
// port checker for dio_exec
// assumes the bench holds op inputs steady while an op runs
`timescale 1ns/1ps
`default_nettype none
`include "dio_map.vh"
module dio_exec_chk (
   input wire logic        mclk, rst_n, op_start, op_done, irq_pending, idle_active,
   input wire logic        interrupt_mask_bit, sign_extension_mode_bit, pc_load, dm_rd,
   input wire logic        io_space_select_n, external_access_strobe, io_rd_n, io_ready, dm_we,
   input wire logic [2:0]  op_code,
   input wire logic [3:0]  shift_count,
   input wire logic [4:0]  soft_k,
   input wire logic [15:0] pc_target, dm_rdata, io_addr, port_address,
   input wire logic [31:0] acc
);
   logic rdy_reg, warm_reg;
   wire  take = op_start && (rdy_reg || op_done);
   // mirror of the accept window: one warm-up edge, then one op at a time
   always @(posedge mclk)
      if (!rst_n) begin
         warm_reg <= 1'b0;
         rdy_reg  <= 1'b0;
      end else begin
         warm_reg <= 1'b1;
         rdy_reg  <= !warm_reg || (take ? 1'b0 : (op_done || rdy_reg));
      end
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence io_on;
      !io_space_select_n && !external_access_strobe && !io_rd_n;
   endsequence
   mask_clear_a: assert property (take && op_code == `DIO_OP_ENABLE_INTERRUPTS_OP |=> op_done && !interrupt_mask_bit)
      else $error("mask not cleared");
   idle_hold_a: assert property (idle_active && !irq_pending |=> idle_active && !op_done)
      else $error("idle left early");
   idle_exit_a: assert property (idle_active && irq_pending |=> !idle_active && op_done)
      else $error("idle not left");
   io_start_a: assert property (take && op_code == `DIO_OP_IN |=>
      io_on and (io_addr == $past(port_address)))
      else $error("io strobes wrong");
   io_wait_a: assert property (take && op_code == `DIO_OP_IN && io_ready |=> io_on [*3] ##1 op_done && dm_we)
      else $error("io read timing");
   swi_vec_a: assert property (take && op_code == `DIO_OP_SWI |=> pc_load && pc_target == {10'h000, $past(soft_k), 1'b0})
      else $error("bad vector");
   vec_range_a: assert property (pc_load |-> pc_target <= `DIO_VEC_LAST && !pc_target[0])
      else $error("vector off grid");
   load_val_a: assert property (dm_rd |=> op_done && acc == (($past(sign_extension_mode_bit) ?
      {{16{$past(dm_rdata[15])}}, $past(dm_rdata)} : {16'h0000, $past(dm_rdata)})
      << $past(shift_count, 2)))
      else $error("bad load");
endmodule // dio_exec_chk
bind dio_exec dio_exec_chk u_chk (
   .mclk(mclk), .rst_n(rst_n), .op_start(op_start), .op_done(op_done),
   .irq_pending(irq_pending), .idle_active(idle_active),
   .interrupt_mask_bit(interrupt_mask_bit), .sign_extension_mode_bit(sign_extension_mode_bit),
   .pc_load(pc_load), .dm_rd(dm_rd), .io_space_select_n(io_space_select_n),
   .external_access_strobe(external_access_strobe), .io_rd_n(io_rd_n), .io_ready(io_ready),
   .dm_we(dm_we), .op_code(op_code), .shift_count(shift_count), .soft_k(soft_k),
   .pc_target(pc_target), .dm_rdata(dm_rdata), .io_addr(io_addr), .port_address(port_address),
   .acc(acc));
`default_nettype wire

// ===== test/dio_io_peer.sv
// external port peripheral model
// assumes active-low select and read strobe from the block
`timescale 1ns/1ps
`default_nettype none
module dio_io_peer (
   input  wire logic        mclk,   // core clock
   input  wire logic        sel_n,  // io space select
   input  wire logic        rd_n,   // read strobe
   input  wire logic        slow,   // 1: hold ready low for a while
   input  wire logic [15:0] addr,   // port address
   output wire logic [15:0] rdata,  // data bus
   output wire logic        ready   // ready pin
);
   logic [3:0]  wait_reg = 4'h0;
   logic [15:0] d_reg    = 16'h0000;
   always @(posedge mclk) begin
      wait_reg <= rd_n ? 4'h0 : wait_reg + {3'h0, wait_reg != 4'hF};
      // off the bus the word toggles so a stale value cannot pass
      d_reg    <= (!sel_n && !rd_n) ? addr ^ 16'hA5C3 : ~d_reg;
   end
   assign rdata = d_reg;
   assign ready = !slow || wait_reg > 4'h6;
endmodule // dio_io_peer
`default_nettype wire

// ===== test/tb.sv
// self-checking bench for dio_exec
// assumes dio_map.vh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "dio_map.vh"
module tb;
   logic mclk = 0, rst_n = 0, op_start = 0, sxm_set = 0, sxm_clr = 0, interrupt_mask_bit_set = 0;
   logic irq_pending = 0, slow = 0;
   logic [2:0] op_code = 0;
   logic [3:0] shift_count = 0;
   logic [4:0] soft_k = 0;
   logic [15:0] dm_addr = 0, port_address = 0, dm_rdata = 0;
   wire [15:0] io_rdata, pc_target, dm_waddr, dm_wdata, io_addr;
   wire io_ready, op_done, idle_active, interrupt_mask_bit, sign_extension_mode_bit, pc_load;
   wire dm_rd, dm_we, io_space_select_n, external_access_strobe, io_rd_n;
   wire [31:0] acc;
   int err_count = 0, n_checks = 0, cyc = 0;
   dio_exec DUT (
      .mclk(mclk), .rst_n(rst_n), .op_start(op_start), .op_code(op_code), .dm_addr(dm_addr),
      .port_address(port_address), .soft_k(soft_k), .shift_count(shift_count),
      .sxm_set(sxm_set), .sxm_clr(sxm_clr), .interrupt_mask_bit_set(interrupt_mask_bit_set), .irq_pending(irq_pending),
      .dm_rdata(dm_rdata), .io_rdata(io_rdata), .io_ready(io_ready), .op_done(op_done),
      .idle_active(idle_active), .interrupt_mask_bit(interrupt_mask_bit),
      .sign_extension_mode_bit(sign_extension_mode_bit), .pc_load(pc_load),
      .pc_target(pc_target), .acc(acc), .dm_rd(dm_rd), .dm_we(dm_we), .dm_waddr(dm_waddr),
      .dm_wdata(dm_wdata), .io_space_select_n(io_space_select_n),
      .external_access_strobe(external_access_strobe), .io_rd_n(io_rd_n), .io_addr(io_addr));
   dio_io_peer u_peer (.mclk(mclk), .sel_n(io_space_select_n), .rd_n(io_rd_n), .slow(slow),
      .addr(io_addr), .rdata(io_rdata), .ready(io_ready));
   initial forever #4 mclk = ~mclk;
   task wrap_up;
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 3000) begin
         err_count++;
         wrap_up;
      end
   end
   task chk(input string nm, input logic [31:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task go(input logic [2:0] c);
      // one idle edge first, so op_start never falls and rises in one time step
      @(negedge mclk);
      op_code = c;
      op_start = 1;
      @(negedge mclk) op_start = 0;
   endtask
   task done_wait;
      for (int t = 0; op_done !== 1'b1 && t < 40; t++) @(negedge mclk);
      chk("op_done", op_done, 1);
   endtask
   task ld(input logic [15:0] w, input logic [3:0] n, input logic sx);
      sxm_set = sx;
      sxm_clr = !sx;
      @(negedge mclk) {sxm_set, sxm_clr} = 2'b00;
      dm_rdata = w;
      shift_count = n;
      go(`DIO_OP_LOAD);
      done_wait;
      chk("sxm", sign_extension_mode_bit, sx);
      chk("acc", acc, (sx ? {{16{w[15]}}, w} : {16'h0000, w}) << n);
   endtask
   initial begin
      repeat (16) @(negedge mclk);
      rst_n = 1;
      repeat (2) @(negedge mclk);
      chk("modes", {interrupt_mask_bit, sign_extension_mode_bit}, 2'b11);
      go(`DIO_OP_ENABLE_INTERRUPTS_OP);
      done_wait;
      chk("mask", interrupt_mask_bit, 0);
      interrupt_mask_bit_set = 1;
      @(negedge mclk) interrupt_mask_bit_set = 0;
      chk("mask set", interrupt_mask_bit, 1);
      go(`DIO_OP_ENABLE_INTERRUPTS_OP);
      done_wait;
      chk("mask again", interrupt_mask_bit, 0);
      $display("test mask done");
      for (int k = 0; k < 32; k++) begin
         soft_k = k[4:0];
         go(`DIO_OP_SWI);
         done_wait;
         chk("vector", {pc_load, pc_target}, 32'h10000 + k * 2);
      end
      go(`DIO_OP_NONE);
      done_wait;
      chk("no op", {pc_load, interrupt_mask_bit}, 2'b00);
      $display("test vector done");
      go(`DIO_OP_IDLE);
      repeat (5) @(negedge mclk);
      chk("idle", {op_done, idle_active}, 2'b01);
      irq_pending = 1;
      @(negedge mclk) irq_pending = 0;
      chk("wake", {op_done, idle_active}, 2'b10);
      $display("test idle done");
      go(`DIO_OP_IDLE);
      repeat (3) @(negedge mclk);
      chk("idle again", idle_active, 1);
      rst_n = 0;
      repeat (2) @(negedge mclk);
      rst_n = 1;
      repeat (2) @(negedge mclk);
      chk("reset wake", {op_done, idle_active, interrupt_mask_bit}, 3'b001);
      $display("test idle reset done");
      for (int s = 0; s < 2; s++) begin
         slow = s[0];
         port_address = 16'h0040 + s[15:0];
         dm_addr = 16'h0200 + s[15:0];
         go(`DIO_OP_IN);
         done_wait;
         chk("io we", dm_we, 1);
         chk("io word", {dm_waddr, dm_wdata}, {dm_addr, port_address ^ 16'hA5C3});
         chk("io rel", io_space_select_n, 1);
      end
      $display("test port done");
      ld(16'h8001, 4'hF, 1);
      ld(16'h8001, 4'h4, 0);
      ld(16'h7FFF, 4'h0, 1);
      ld(16'hFFFF, 4'h1, 1);
      $display("test load done");
      wrap_up;
   end
endmodule // tb
`default_nettype wire
